// ---- core/pmes_pkg.sv ----
// package: constants and types for the pulse module error status block
// Operation
// [R1] undervoltage flag only when supply present but low
// [R2] sensor supply fault sticky until clear request
// [R3] one-shot load failure sticky, blocks auxiliary field
// [R4] pulse output error flag follows its condition
// [R5] output A short sticky until clear request
// [R6] output B short or manual both-high, sticky
// [R7] setpoint invalid flag clears on valid read
// [R8] aux invalid flag, continuous mode only
// [R9] channel 0 status byte 0, channel 1 byte 8
// [R10] invalid flags read zero while value valid
// [R11] clear request resets four sticky flags while high
// [R12] channel 1 status only in two-channel configuration
// [R13] persisting cause sets flag again after release
`default_nettype none
package pmes_pkg;
	// register byte offsets
	localparam logic [7:0] PMES_OFS_ERR0    = 8'h00;
	localparam logic [7:0] PMES_OFS_ERR1    = 8'h08;
	localparam logic [7:0] PMES_OFS_CTRL0   = 8'h10;
	localparam logic [7:0] PMES_OFS_CTRL1   = 8'h14;
	localparam logic [7:0] PMES_OFS_CFG     = 8'h18;
	localparam logic [7:0] PMES_OFS_IRQ_STS = 8'h1c;
	localparam logic [7:0] PMES_OFS_IRQ_MSK = 8'h20;
	// error status bit positions
	localparam int PMES_BIT_UV     = 0;
	localparam int PMES_BIT_SENSOR = 1;
	localparam int PMES_BIT_LOAD   = 2;
	localparam int PMES_BIT_PULSE  = 3;
	localparam int PMES_BIT_OUTA   = 4;
	localparam int PMES_BIT_OUTB   = 5;
	localparam int PMES_BIT_SETPT  = 6;
	localparam int PMES_BIT_AUX    = 7;
	// control register bit positions
	localparam int PMES_CTL_CLR = 0;
	localparam int PMES_CTL_SRC = 1;
	localparam int PMES_CTL_MA  = 3;
	localparam int PMES_CTL_MB  = 4;
	// configuration register bit positions
	localparam int PMES_CFG_TWO   = 0;
	localparam int PMES_CFG_CONT0 = 1;
	// reset values
	localparam logic [7:0]  PMES_CTRL_RST = 8'h00;
	localparam logic [2:0]  PMES_CFG_RST  = 3'h1;
	localparam logic [15:0] PMES_MSK_RST  = 16'h0000;
	localparam logic [7:0]  PMES_FLAG_RST = 8'h00;
	// condition inputs of one channel
	typedef struct packed {
		logic supplyPresent;  // module supply detected
		logic supplyLow;      // module supply below limit
		logic sensorFault;    // switched supply short/overload
		logic loadFail;       // one-shot load attempt failed
		logic pulseError;     // pulse output error present
		logic shortA;         // short on pin A
		logic shortB;         // short on pin B
		logic setpointStrobe; // setpoint value read this cycle
		logic setpointValid;  // that setpoint value is valid
		logic auxStrobe;      // auxiliary value read this cycle
		logic auxValid;       // that auxiliary value is valid
	} pmes_cond_t;
	// control bits of one channel
	typedef struct packed {
		logic clearReq;     // clear_errors_request
		logic sourceSelect; // output_source_select
		logic manualA;      // manual_level_a
		logic manualB;      // manual_level_b
	} pmes_ctrl_t;
endpackage
`default_nettype wire

// ---- core/pmes_chan_flags.sv ----
// module: error flags of one pulse output channel
`timescale 1ns/100ps
`default_nettype none
module pmes_chan_flags
	import pmes_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	// conditions and control
	input  wire pmes_cond_t cond,
	input  wire pmes_ctrl_t ctrl,
	input  wire logic       continuousMode,
	// flag byte
	output logic [7:0]      flags_q
);
	logic manualBoth;   // manual drive of both pins high
	logic uvFlag_q;     // supply present but low
	logic pulseFlag_q;  // pulse output error present
	logic sensorFlag_q; // sensor supply fault, sticky
	logic loadFlag_q;   // one-shot load failure, sticky
	logic outAFlag_q;   // pin A short, sticky
	logic outBFlag_q;   // pin B short or both-high, sticky
	logic setptFlag_q;  // last setpoint read was invalid
	logic auxFlag_q;    // last auxiliary read was invalid
	assign manualBoth = !ctrl.sourceSelect && ctrl.manualA && ctrl.manualB;

	// level flags follow their condition each cycle
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			uvFlag_q    <= 1'b0;
			pulseFlag_q <= 1'b0;
		end
		else
		begin
			uvFlag_q    <= cond.supplyPresent && cond.supplyLow; // see [R1]
			pulseFlag_q <= cond.pulseError; // see [R4]
		end
	end

	// sticky flags: clear request held high wins, cause re-sets after release
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sensorFlag_q <= 1'b0;
			loadFlag_q   <= 1'b0;
			outAFlag_q   <= 1'b0;
			outBFlag_q   <= 1'b0;
		end
		else if (ctrl.clearReq)
		begin
			// see [R11]
			sensorFlag_q <= 1'b0;
			loadFlag_q   <= 1'b0;
			outAFlag_q   <= 1'b0;
			outBFlag_q   <= 1'b0;
		end
		else
		begin
			// persisting causes set again here, see [R13]
			if (cond.sensorFault)
				sensorFlag_q <= 1'b1; // see [R2]
			if (cond.loadFail && !continuousMode)
				loadFlag_q <= 1'b1; // see [R3]
			if (cond.shortA)
				outAFlag_q <= 1'b1; // see [R5]
			if (cond.shortB || manualBoth)
				outBFlag_q <= 1'b1; // see [R6]
		end
	end

	// setpoint flag updates only on a setpoint read; aux flag updates on an aux read, held at zero outside continuous mode
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			setptFlag_q <= 1'b0;
			auxFlag_q   <= 1'b0;
		end
		else
		begin
			if (cond.setpointStrobe)
				setptFlag_q <= !cond.setpointValid; // see [R7] [R10]
			if (!continuousMode)
				auxFlag_q <= 1'b0; // see [R8]
			else if (cond.auxStrobe)
				auxFlag_q <= !cond.auxValid; // see [R8] [R10]
		end
	end

	// flag byte assembled by bit position, one driver for all bits
	always_comb
	begin
		flags_q                  = PMES_FLAG_RST;
		flags_q[PMES_BIT_UV]     = uvFlag_q;
		flags_q[PMES_BIT_SENSOR] = sensorFlag_q;
		flags_q[PMES_BIT_LOAD]   = loadFlag_q;
		flags_q[PMES_BIT_PULSE]  = pulseFlag_q;
		flags_q[PMES_BIT_OUTA]   = outAFlag_q;
		flags_q[PMES_BIT_OUTB]   = outBFlag_q;
		flags_q[PMES_BIT_SETPT]  = setptFlag_q;
		flags_q[PMES_BIT_AUX]    = auxFlag_q;
	end
endmodule
`default_nettype wire

// ---- core/pmes_irq.sv ----
// module: sticky interrupt status with mask and level output
`timescale 1ns/100ps
`default_nettype none
module pmes_irq
	import pmes_pkg::*;
#(
	parameter int W = 16
)
(
	// clock and reset
	input  wire logic         clk,
	input  wire logic         reset_n,
	// events and software side
	input  wire logic [W-1:0] events,
	input  wire logic         readClear,
	input  wire logic [W-1:0] mask,
	// results
	output logic [W-1:0]      status_q,
	output logic              irq
);
	// read clears, a new event in the same cycle still lands
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			status_q <= '0;
		else
			status_q <= (readClear ? '0 : status_q) | events;
	end

	// one level output over all unmasked bits
	assign irq = |(status_q & mask);
endmodule
`default_nettype wire

// ---- core/pmes_error_status.sv ----
// module: error status bank of a two-channel pulse output module
//
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module pmes_error_status
	import pmes_pkg::*;
#(
	parameter int CH = 2 // channel count
)
(
	// clock and reset
	input  wire logic                clk,
	input  wire logic                reset_n,
	// apb slave
	input  wire logic [7:0]          paddr,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [31:0]         pwdata,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	// channel conditions
	input  wire pmes_cond_t [CH-1:0] cond,
	// sequence driven pin levels
	input  wire logic [CH-1:0]       seqA,
	input  wire logic [CH-1:0]       seqB,
	// pin drive
	output logic [CH-1:0]            pulsePinA,
	output logic [CH-1:0]            pulsePinB,
	// auxiliary field usable
	output logic [CH-1:0]            slotUsable,
	// interrupt
	output logic                     irq
);
	// control registers, one per channel
	logic [7:0]       ctrl_q [CH];
	// configuration register
	logic [2:0]       cfg_q;
	// interrupt mask
	logic [15:0]      mask_q;
	// read data register
	logic [31:0]      prdata_q;
	// flag bytes
	logic [7:0]       flags [CH];
	// flags seen last cycle
	logic [7:0]       flagsPrev_q [CH];
	// decoded control per channel
	pmes_ctrl_t       ctrlBits [CH];
	// channel enabled by configuration
	logic [CH-1:0]    chanOn;
	// continuous load mode per channel
	logic [CH-1:0]    contMode;
	// conditions as seen by each channel
	pmes_cond_t       condGated [CH];
	// interrupt events and status
	logic [15:0]      irqEvents;
	logic [15:0]      irqStatus;
	// status bits that arrived after the read snapshot
	logic [15:0]      irqKeep;
	// bus phases
	logic             setupPh;
	logic             accessPh;
	logic             wrAcc;
	logic             rdAcc;
	// address decode
	logic             hitErr0;
	logic             hitErr1;
	logic             hitCtrl0;
	logic             hitCtrl1;
	logic             hitCfg;
	logic             hitSts;
	logic             hitMsk;
	logic             hitAny;
	// read data picked in setup
	logic [31:0]      rdMux;

	// bus phase decode
	assign setupPh  = psel && !penable;
	assign accessPh = psel && penable;
	assign wrAcc    = accessPh && pwrite;
	assign rdAcc    = accessPh && !pwrite;

	// register map, byte offsets, one 32-bit word each:
	//   0x00 channel 0 error status, read only
	//   0x08 channel 1 error status, read only, zero with one channel
	//   0x10 channel 0 control
	//   0x14 channel 1 control
	//   0x18 configuration
	//   0x1c interrupt status, cleared by its read
	//   0x20 interrupt mask
	// error status byte layout:
	//   bit 0 supply undervoltage, follows its cause
	//   bit 1 sensor supply fault, sticky
	//   bit 2 one-shot load failure, sticky
	//   bit 3 pulse output error, follows its cause
	//   bit 4 pin A short, sticky
	//   bit 5 pin B short or manual both-high, sticky
	//   bit 6 setpoint invalid, updated on a setpoint read
	//   bit 7 auxiliary value invalid, continuous mode only
	// control byte layout:
	//   bit 0 clear request, a level that wins over the causes of the four sticky flags
	//   bit 1 source select, 1 hands the pins to the sequence
	//   bit 3 manual level of pin A
	//   bit 4 manual level of pin B
	// configuration layout:
	//   bit 0 two-channel setup, enables channel 1
	//   bit 1 continuous load mode of channel 0
	//   bit 2 continuous load mode of channel 1
	// flags trail their cause by one cycle, interrupt status by two

	// address decode, whole aligned words only
	assign hitErr0  = (paddr == PMES_OFS_ERR0);
	assign hitErr1  = (paddr == PMES_OFS_ERR1);
	assign hitCtrl0 = (paddr == PMES_OFS_CTRL0);
	assign hitCtrl1 = (paddr == PMES_OFS_CTRL1);
	assign hitCfg   = (paddr == PMES_OFS_CFG);
	assign hitSts   = (paddr == PMES_OFS_IRQ_STS);
	assign hitMsk   = (paddr == PMES_OFS_IRQ_MSK);
	assign hitAny   = hitErr0 || hitErr1 || hitCtrl0 || hitCtrl1
		|| hitCfg || hitSts || hitMsk;

	// zero wait state: every access phase completes at once
	assign pready  = 1'b1;
	// unmapped address answers with an error
	assign pslverr = accessPh && !hitAny;
	// read data held in a register from the setup cycle
	assign prdata  = prdata_q;

	// a status read clears only the bits it reported; bits that
	// landed after the setup snapshot survive into the next read
	assign irqKeep = (rdAcc && hitSts) ? (irqStatus & ~prdata_q[15:0]) : 16'h0000;

	// configuration bits to channel controls
	assign chanOn[0]   = 1'b1;
	assign contMode[0] = cfg_q[PMES_CFG_CONT0];

	// per-channel enable, mode and control fields
	genvar g;
	generate
		for (g = 0; g < CH; g++)
		begin : gChan
			if (g > 0)
			begin : gUpper
				// upper channel only in two-channel setup, see [R12]
				assign chanOn[g]   = cfg_q[PMES_CFG_TWO];
				assign contMode[g] = cfg_q[PMES_CFG_CONT0 + 1];
			end
			// field view of the control byte
			assign ctrlBits[g].clearReq     = ctrl_q[g][PMES_CTL_CLR];
			assign ctrlBits[g].sourceSelect = ctrl_q[g][PMES_CTL_SRC];
			assign ctrlBits[g].manualA      = ctrl_q[g][PMES_CTL_MA];
			assign ctrlBits[g].manualB      = ctrl_q[g][PMES_CTL_MB];
			// a disabled channel sees no faults
			assign condGated[g] = chanOn[g] ? cond[g] : '0;
			// flag logic of this channel
			pmes_chan_flags uFlags
			(
				.clk            (clk),
				.reset_n        (reset_n),
				.cond           (condGated[g]),
				.ctrl           (ctrlBits[g]),
				.continuousMode (contMode[g]),
				.flags_q        (flags[g])
			);
			// rising flag edges become interrupt events
			assign irqEvents[8*g +: 8] = flags[g] & ~flagsPrev_q[g];
		end
	endgenerate

	// unused event bits above the channel count
	if (CH < 2)
	begin : gPadEv
		assign irqEvents[15:8*CH] = '0;
	end

	// flag history for edge detection
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			// no history, so no false edge after reset
			for (int i = 0; i < CH; i++)
				flagsPrev_q[i] <= PMES_FLAG_RST;
		end
		else
		begin
			// remember this cycle's flags
			for (int i = 0; i < CH; i++)
				flagsPrev_q[i] <= flags[i];
		end
	end

	// control register writes
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (int i = 0; i < CH; i++)
				ctrl_q[i] <= PMES_CTRL_RST;
		end
		else if (wrAcc)
		begin
			// only the defined control bits are kept
			if (hitCtrl0)
			begin
				// channel 0 control byte
				ctrl_q[0] <= pwdata[7:0] & 8'h1b;
			end
			if (hitCtrl1 && CH > 1)
			begin
				// upper channel control byte, absent with one channel
				ctrl_q[CH-1] <= pwdata[7:0] & 8'h1b;
			end
		end
	end

	// configuration register write
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			cfg_q <= PMES_CFG_RST;
		else if (wrAcc && hitCfg)
			cfg_q <= pwdata[2:0];
	end

	// interrupt mask write
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			mask_q <= PMES_MSK_RST;
		else if (wrAcc && hitMsk)
			mask_q <= pwdata[15:0];
	end

	// sticky interrupt status, cleared by its read
	pmes_irq #(
		.W (16)
	) uIrq
	(
		.clk       (clk),
		.reset_n   (reset_n),
		.events    (irqEvents | irqKeep),
		.readClear (rdAcc && hitSts),
		.mask      (mask_q),
		.status_q  (irqStatus),
		.irq       (irq)
	);

	// read multiplexer
	always_comb
	begin
		rdMux = 32'h0000_0000;
		if (hitErr0)
		begin
			// channel 0 status, see [R9]
			rdMux[7:0] = flags[0];
		end
		else if (hitErr1)
		begin
			// channel 1 status reads zero unless two channels, see [R9] [R12]
			if (CH > 1 && chanOn[CH-1])
				rdMux[7:0] = flags[CH-1];
		end
		else if (hitCtrl0)
		begin
			rdMux[7:0] = ctrl_q[0];
		end
		else if (hitCtrl1)
		begin
			if (CH > 1)
				rdMux[7:0] = ctrl_q[CH-1];
		end
		else if (hitCfg)
		begin
			rdMux[2:0] = cfg_q;
		end
		else if (hitSts)
		begin
			rdMux[15:0] = irqStatus;
		end
		else if (hitMsk)
		begin
			rdMux[15:0] = mask_q;
		end
		else
		begin
			// unmapped reads as zero
			rdMux = 32'h0000_0000;
		end
	end

	// read data captured in the setup cycle
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			prdata_q <= 32'h0000_0000;
		else if (setupPh && !pwrite)
			prdata_q <= rdMux;
	end

	// pin drive: sequence or manual levels
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pulsePinA <= '0;
			pulsePinB <= '0;
		end
		else
		begin
			for (int i = 0; i < CH; i++)
			begin
				if (!chanOn[i])
				begin
					// disabled channel keeps pins low
					pulsePinA[i] <= 1'b0;
					pulsePinB[i] <= 1'b0;
				end
				else if (ctrlBits[i].sourceSelect)
				begin
					// sequence owns the pins
					pulsePinA[i] <= seqA[i];
					pulsePinB[i] <= seqB[i];
				end
				else
				begin
					// manual: both high refused, pin B held low, see [R6]
					pulsePinA[i] <= ctrlBits[i].manualA;
					pulsePinB[i] <= ctrlBits[i].manualB && !ctrlBits[i].manualA;
				end
			end
		end
	end

	// auxiliary field locked while load failure pending
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			slotUsable <= '0;
		else
		begin
			for (int i = 0; i < CH; i++)
				slotUsable[i] <= chanOn[i] && !flags[i][PMES_BIT_LOAD]; // see [R3]
		end
	end
endmodule
`default_nettype wire

// ---- verification/pmes_error_status_checker.sv ----
// checker: port level assertions of the error status bank
`timescale 1ns/100ps
`default_nettype none
module pmes_error_status_checker
	import pmes_pkg::*;
#(
	parameter int CH = 2 // channel count
)
(
	// clock and reset
	input wire logic                clk,
	input wire logic                reset_n,
	// apb
	input wire logic [7:0]          paddr,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [31:0]         pwdata,
	input wire logic [31:0]         prdata,
	input wire logic                pready,
	input wire logic                pslverr,
	// channel side
	input wire pmes_cond_t [CH-1:0] cond,
	input wire logic [CH-1:0]       seqA,
	input wire logic [CH-1:0]       seqB,
	input wire logic [CH-1:0]       pulsePinA,
	input wire logic [CH-1:0]       pulsePinB,
	input wire logic [CH-1:0]       slotUsable,
	input wire logic                irq
);
	logic       acc;   // access edge
	logic       rd0;   // read of channel 0 status
	logic       mapd;  // address is mapped
	logic       uvC;   // undervoltage cause
	logic       manC;  // manual both-high command
	logic [4:0] ctl_q; // mirror of channel 0 control
	assign acc = psel && penable;
	assign rd0 = acc && !pwrite && paddr == PMES_OFS_ERR0;
	assign mapd = paddr inside {8'h00, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
	assign uvC = cond[0].supplyPresent && cond[0].supplyLow;
	assign manC = !ctl_q[1] && ctl_q[3] && ctl_q[4];
	// follow software writes to channel 0 control
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			ctl_q <= 5'h00;
		else if (acc && pwrite && paddr == PMES_OFS_CTRL0)
			ctl_q <= pwdata[4:0];
	end
	default clocking dc @(posedge clk); endclocking
	default disable iff (!reset_n);
	unmapped_refused_a: assert property (
		acc && !mapd |-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (
		acc && mapd |-> !pslverr && (pwrite || prdata[31:16] == 16'h0))
		else $error("mapped access refused");
	undervoltage_flag_a: assert property (
		rd0 |-> prdata[0] == $past(uvC, 2))
		else $error("undervoltage flag wrong");
	pulse_flag_a: assert property (
		rd0 |-> prdata[3] == $past(cond[0].pulseError, 2))
		else $error("pulse error flag wrong");
	clear_wins_a: assert property (
		rd0 && $past(ctl_q[0], 2) |-> (prdata & 32'h36) == 32'h0)
		else $error("sticky flag seen during clear");
	sensor_sticky_a: assert property (
		rd0 && $past(cond[0].sensorFault, 2) && !$past(ctl_q[0], 2) |-> prdata[1])
		else $error("sensor fault flag missing");
	both_high_flag_a: assert property (
		rd0 && $past(manC, 2) && !$past(ctl_q[0], 2) |-> prdata[5])
		else $error("both-high command not flagged");
	pin_guard_a: assert property (
		manC |=> pulsePinA[0] && !pulsePinB[0])
		else $error("both pins driven high");
	pin_sequence_a: assert property (
		ctl_q[1] |=> pulsePinA[0] == $past(seqA[0]) && pulsePinB[0] == $past(seqB[0]))
		else $error("pins do not follow sequence");
endmodule
bind pmes_error_status pmes_error_status_checker #(.CH(CH)) chk (.clk(clk), .reset_n(reset_n),
	.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .cond(cond), .seqA(seqA),
	.seqB(seqB), .pulsePinA(pulsePinA), .pulsePinB(pulsePinB), .slotUsable(slotUsable),
	.irq(irq));
`default_nettype wire

// ---- verification/pmes_cpu_model.sv ----
// cpu model: apb master reading and writing the error status registers
`timescale 1ns/100ps
`default_nettype none
module pmes_cpu_model
(
	// clock
	input  wire logic        clk,
	// slave answer
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	// request
	output logic [7:0]       paddr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [31:0]      pwdata
);
	// idle bus at time zero
	initial
	begin
		paddr = 8'h00;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0;
	end
	// one transfer, held until pready is seen
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		// released bus shows no stale values
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~wd;
	endtask
	// raise and drop the clear request
	task automatic clearErrors;
		logic [31:0] d;
		logic        e;
		xfer(1'b1, 8'h10, 32'h1, d, e);
		xfer(1'b1, 8'h10, 32'h0, d, e);
	endtask
endmodule
`default_nettype wire

// ---- verification/test_pulse_module_error_status.sv ----
// testbench: register level tests of the error status bank
`timescale 1ns/100ps
`default_nettype none
module test_pulse_module_error_status
	import pmes_pkg::*;
;
	logic             clk = 1'b0; // bench clock
	logic             reset_n;    // bench reset
	logic [7:0]       paddr;
	logic             psel;
	logic             penable;
	logic             pwrite;
	logic [31:0]      pwdata;
	logic [31:0]      prdata;
	logic             pready;
	logic             pslverr;
	pmes_cond_t [1:0] cond;       // channel conditions
	logic [1:0]       seqA;
	logic [1:0]       seqB;
	logic [1:0]       pinA;
	logic [1:0]       pinB;
	logic [1:0]       slotOk;
	logic             irq;
	logic [31:0]      rdat;       // last read data
	logic             rerr;       // last error answer
	int               errors;
	int               samplesChecked;
	always #50 clk = ~clk;
	pmes_error_status uut (.clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cond(cond), .seqA(seqA), .seqB(seqB),
		.pulsePinA(pinA), .pulsePinB(pinB), .slotUsable(slotOk), .irq(irq));
	pmes_cpu_model cpu (.clk(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata));
	// compare and count
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		cpu.xfer(1'b1, a, d, rdat, rerr);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		cpu.xfer(1'b0, a, 32'h0, rdat, rerr);
		chk("prdata", rdat, e);
	endtask
	// one value read strobe on channel 0
	task automatic strobe(input logic aux, input logic ok);
		@(posedge clk);
		cond[0].setpointStrobe <= !aux;
		cond[0].auxStrobe <= aux;
		cond[0].setpointValid <= ok;
		cond[0].auxValid <= ok;
		@(posedge clk);
		cond[0].setpointStrobe <= 1'b0;
		cond[0].auxStrobe <= 1'b0;
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", samplesChecked, errors);
		if (errors == 0 && samplesChecked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// hang guard
	initial
	begin
		#1000000;
		errors++;
		give_verdict();
	end
	initial
	begin
		reset_n = 1'b0;
		cond = '0;
		seqA = 2'h0;
		seqB = 2'h0;
		errors = 0;
		samplesChecked = 0;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		// reset values and map
		rdc(8'h00, 32'h0);
		rdc(8'h10, 32'h0);
		rdc(8'h18, 32'h1);
		rdc(8'h04, 32'h0);
		chk("pslverr", {31'h0, rerr}, 32'h1);
		// undervoltage needs supply present
		cond[0].supplyPresent <= 1'b1;
		cond[0].supplyLow <= 1'b1;
		rdc(8'h00, 32'h01);
		cond[0].supplyPresent <= 1'b0;
		rdc(8'h00, 32'h00);
		cond[0].pulseError <= 1'b1;
		rdc(8'h00, 32'h08);
		cond[0].pulseError <= 1'b0;
		rdc(8'h00, 32'h00);
		// sticky faults raise interrupt
		wr(8'h20, 32'h12);
		cond[0].sensorFault <= 1'b1;
		cond[0].shortA <= 1'b1;
		repeat (2) @(posedge clk);
		cond[0].shortA <= 1'b0;
		rdc(8'h00, 32'h12);
		@(negedge clk);
		chk("irq", {31'h0, irq}, 32'h1);
		// earlier undervoltage and pulse flag rises are latched as well
		rdc(8'h1c, 32'h1b);
		@(negedge clk);
		chk("irq", {31'h0, irq}, 32'h0);
		// clear wins over a persisting cause
		wr(8'h10, 32'h1);
		rdc(8'h00, 32'h00);
		wr(8'h10, 32'h0);
		rdc(8'h00, 32'h02);
		cond[0].sensorFault <= 1'b0;
		rdc(8'h1c, 32'h02);
		cpu.clearErrors();
		// manual both high, masked event; pins settle one edge after the write
		wr(8'h10, 32'h18);
		repeat (2) @(negedge clk);
		chk("pins", {30'h0, pinB[0], pinA[0]}, 32'h1);
		rdc(8'h00, 32'h20);
		@(negedge clk);
		chk("irq", {31'h0, irq}, 32'h0);
		wr(8'h10, 32'h02);
		seqB <= 2'h1;
		repeat (2) @(negedge clk);
		chk("pins", {30'h0, pinB[0], pinA[0]}, 32'h2);
		cpu.clearErrors();
		rdc(8'h00, 32'h00);
		// one-shot load failure blocks the field
		cond[0].loadFail <= 1'b1;
		@(posedge clk);
		cond[0].loadFail <= 1'b0;
		repeat (2) @(negedge clk);
		chk("slot", {31'h0, slotOk[0]}, 32'h0);
		rdc(8'h00, 32'h04);
		cpu.clearErrors();
		@(negedge clk);
		chk("slot", {31'h0, slotOk[0]}, 32'h1);
		// value checks on read strobes
		strobe(1'b0, 1'b0);
		rdc(8'h00, 32'h40);
		strobe(1'b0, 1'b1);
		rdc(8'h00, 32'h00);
		strobe(1'b1, 1'b0);
		rdc(8'h00, 32'h00);
		wr(8'h18, 32'h3);
		strobe(1'b1, 1'b0);
		rdc(8'h00, 32'h80);
		strobe(1'b1, 1'b1);
		rdc(8'h00, 32'h00);
		cond[0].loadFail <= 1'b1;
		@(posedge clk);
		cond[0].loadFail <= 1'b0;
		rdc(8'h00, 32'h00);
		// second channel and its configuration
		cond[1].shortA <= 1'b1;
		@(posedge clk);
		cond[1].shortA <= 1'b0;
		rdc(8'h08, 32'h10);
		wr(8'h18, 32'h0);
		rdc(8'h08, 32'h00);
		give_verdict();
	end
endmodule
`default_nettype wire
